// ### rtl/mte_timer_ctrl.sv
// Purpose: run control, read latching and event routing of a radio MAC timer
// Assumes: counter datapaths sit outside and feed events and values on clk_i
// Notes: slow_clk_i is a pin and passes two flip-flops before use
//
// Contract
// - latch mode 0: low count read captures high
// - latch mode 0: wrap byte0 read captures upper
// - latch mode 1: low count read captures all
// - sync 0: start and stop act at once
// - sync 1 (reset): wait for slow clock rise
// - run bit requests start/stop, reads back written
// - narrow event b field bits 6:4 codes
// - narrow event a field bits 2:0, reserved zero
// - wide event b field bits 7:4, joint codes
// - wide event a field bits 3:0, same codes
// - joint match is wrap equal plus count match
// - wrap event comes from counter wrapping to zero
`timescale 1ns/10ps
module mte_timer_ctrl
   import mte_pkg::*;
#(
   parameter int EVT_W = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DAT_W-1:0] wb_dat_i,
   output logic [DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // slow clock pin
   input wire logic slow_clk_i,
   // timer datapath events and values
   input wire logic count_wrap_evt_i,
   input wire logic count_match_a_evt_i,
   input wire logic count_match_b_evt_i,
   input wire logic wrap_count_wrap_evt_i,
   input wire logic wrap_count_match_a_evt_i,
   input wire logic wrap_count_match_b_evt_i,
   input wire logic wrap_at_match_a_i,
   input wire logic wrap_at_match_b_i,
   input wire logic [15:0] count_value_i,
   input wire logic [23:0] wrap_count_i,
   // outputs
   output logic pulse_a_out_o,
   output logic pulse_b_out_o,
   output logic timer_running_o,
   output logic irq_o
);
   localparam logic [7:0] EVT_MASK = (EVT_W == 4) ? EVT_MASK_WIDE : EVT_MASK_NARROW;
   localparam logic JOINT_EN = (EVT_W == 4);

   // registers
   logic ack_q;
   logic [DAT_W-1:0] rdat_q;
   logic run_q;
   logic sync_q;
   logic latch_q;
   logic pend_q;
   mte_state_t state_q;
   logic [7:0] evt_q;
   logic [7:0] vsel_q;
   logic [7:0] cnt_hi_q;
   logic [23:0] wrap_lat_q;
   logic [IRQ_N-1:0] sts_q;
   logic [IRQ_N-1:0] en_q;
   logic slow_s1_q;
   logic slow_s2_q;
   logic slow_s3_q;
   logic [1:0] pulse_q;

   // bus decode
   wire req = wb_cyc_i & wb_stb_i;
   wire acc = req & ~ack_q;
   wire wr_acc = acc & wb_we_i & wb_sel_i[0];
   wire rd_acc = acc & ~wb_we_i;
   wire [7:0] wbyte = wb_dat_i[7:0];
   wire hit_ctrl = wb_adr_i == OFS_CTRL;
   wire hit_vsel = wb_adr_i == OFS_VIEW_SEL;
   wire hit_lo = wb_adr_i == OFS_CNT_LO;
   wire hit_hi = wb_adr_i == OFS_CNT_HI;
   wire hit_w0 = wb_adr_i == OFS_WRAP0;
   wire hit_w1 = wb_adr_i == OFS_WRAP1;
   wire hit_w2 = wb_adr_i == OFS_WRAP2;
   wire hit_evt = wb_adr_i == OFS_EVT_SEL;
   wire hit_sts = wb_adr_i == OFS_IRQ_STS;
   wire hit_clr = wb_adr_i == OFS_IRQ_CLR;
   wire hit_en = wb_adr_i == OFS_IRQ_EN;

   // view selector fields
   wire [2:0] cnt_view = vsel_q[VSEL_CNT_LSB +: 3];
   wire [2:0] wrap_view = vsel_q[VSEL_WRAP_LSB +: 3];
   wire cnt_live = cnt_view == VSEL_LIVE;
   wire wrap_live = wrap_view == VSEL_LIVE;

   // capture strobes
   wire rd_lo = rd_acc & hit_lo & cnt_live;
   wire rd_w0 = rd_acc & hit_w0 & wrap_live;
   wire cap_hi = rd_lo;
   wire cap_wrap_all = rd_lo & latch_q;
   wire cap_wrap_up = rd_w0 & ~latch_q;

   // run control
   wire slow_rise = slow_s2_q & ~slow_s3_q;
   wire go_now = pend_q & ~sync_q;
   wire go_slow = pend_q & sync_q & slow_rise;
   wire apply = go_now | go_slow;
   wire running = state_q == MTE_RUNNING;
   wire start_evt = apply & run_q & ~running;
   wire stop_evt = apply & ~run_q & running;

   // event sources
   wire joint_a = wrap_at_match_a_i & count_match_a_evt_i;
   wire joint_b = wrap_at_match_b_i & count_match_b_evt_i;
   logic [SRC_N-1:0] src;
   always_comb begin
      src = '0;
      src[SRC_CNT_WRAP] = count_wrap_evt_i;
      src[SRC_CNT_MA] = count_match_a_evt_i;
      src[SRC_CNT_MB] = count_match_b_evt_i;
      src[SRC_WRAP_WRAP] = wrap_count_wrap_evt_i;
      src[SRC_WRAP_MA] = wrap_count_match_a_evt_i;
      src[SRC_WRAP_MB] = wrap_count_match_b_evt_i;
      src[SRC_JOINT_A] = JOINT_EN & joint_a;
      src[SRC_JOINT_B] = JOINT_EN & joint_b;
   end

   // event select fields, narrow variant keeps top bits zero
   wire [3:0] code_a = evt_q[EVT_A_LSB +: 4];
   wire [3:0] code_b = evt_q[EVT_B_LSB +: 4];
   wire [3:0] code [2];
   assign code[0] = code_a;
   assign code[1] = code_b;

   // read mux
   wire [7:0] ctrl_rd = {4'h0, latch_q, running, sync_q, run_q};
   wire [7:0] lo_rd = cnt_live ? count_value_i[7:0] : 8'h00;
   wire [7:0] hi_rd = cnt_live ? cnt_hi_q : 8'h00;
   wire [7:0] w0_val = latch_q ? wrap_lat_q[7:0] : wrap_count_i[7:0];
   wire [7:0] w0_rd = wrap_live ? w0_val : 8'h00;
   wire [7:0] w1_rd = wrap_live ? wrap_lat_q[15:8] : 8'h00;
   wire [7:0] w2_rd = wrap_live ? wrap_lat_q[23:16] : 8'h00;
   wire [7:0] byte_rd =
      hit_ctrl ? ctrl_rd :
      hit_vsel ? vsel_q :
      hit_lo ? lo_rd :
      hit_hi ? hi_rd :
      hit_w0 ? w0_rd :
      hit_w1 ? w1_rd :
      hit_w2 ? w2_rd :
      hit_evt ? evt_q :
      hit_sts ? {4'h0, sts_q} :
      hit_en ? {4'h0, en_q} :
      8'h00;

   // bus slave
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q <= acc;
         if (rd_acc) begin
            rdat_q <= {24'h0, byte_rd};
         end
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // control and configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= CTRL_RUN_RST;
         sync_q <= CTRL_SYNC_RST;
         latch_q <= CTRL_LATCH_RST;
         evt_q <= EVT_RST;
         vsel_q <= 8'h00;
         en_q <= '0;
      end else if (wr_acc) begin
         if (hit_ctrl) begin
            run_q <= wbyte[CTRL_RUN];
            sync_q <= wbyte[CTRL_SYNC];
            latch_q <= wbyte[CTRL_LATCH];
         end
         if (hit_evt) begin
            evt_q <= wbyte & EVT_MASK;
         end
         if (hit_vsel) begin
            vsel_q <= wbyte & VSEL_MASK;
         end
         if (hit_en) begin
            en_q <= wbyte[IRQ_N-1:0];
         end
      end
   end

   // slow clock synchroniser and edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_s1_q <= 1'b0;
         slow_s2_q <= 1'b0;
         slow_s3_q <= 1'b0;
      end else begin
         slow_s1_q <= slow_clk_i;
         slow_s2_q <= slow_s1_q;
         slow_s3_q <= slow_s2_q;
      end
   end

   // start and stop sequencing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
         state_q <= MTE_IDLE;
      end else begin
         if (wr_acc && hit_ctrl) begin
            pend_q <= 1'b1;
         end else if (apply) begin
            pend_q <= 1'b0;
         end
         if (apply) begin
            state_q <= run_q ? MTE_RUNNING : MTE_IDLE;
         end
      end
   end
   assign timer_running_o = running;

   // read latches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_hi_q <= 8'h00;
         wrap_lat_q <= 24'h0;
      end else begin
         if (cap_hi) begin
            cnt_hi_q <= count_value_i[15:8];
         end
         if (cap_wrap_all) begin
            wrap_lat_q <= wrap_count_i;
         end else if (cap_wrap_up) begin
            wrap_lat_q[23:8] <= wrap_count_i[23:8];
         end
      end
   end

   // event pulse outputs
   for (genvar g = 0; g < 2; g++) begin : g_pulse
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pulse_q[g] <= 1'b0;
         end else begin
            pulse_q[g] <= src[code[g]];
         end
      end
   end
   assign pulse_a_out_o = pulse_q[0];
   assign pulse_b_out_o = pulse_q[1];

   // interrupt status, set wins over clear
   wire [IRQ_N-1:0] sts_set = {stop_evt, start_evt, pulse_q[1], pulse_q[0]};
   wire [IRQ_N-1:0] sts_clr = (wr_acc && hit_clr) ? wbyte[IRQ_N-1:0] : '0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sts_q <= '0;
      end else begin
         sts_q <= (sts_q & ~sts_clr) | sts_set;
      end
   end
   assign irq_o = |(sts_q & en_q);

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_ctrl_write;
      wr_acc && hit_ctrl;
   endsequence

   sequence s_lo_read;
      rd_acc && hit_lo && cnt_live;
   endsequence

   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_run_readback: assert property (
      s_ctrl_write |=> run_q == $past(wb_dat_i[CTRL_RUN]))
      else $error("run bit does not read back written value");

   a_sync_immediate: assert property (
      pend_q && !sync_q |=> running == $past(run_q) && !pend_q)
      else $error("immediate start or stop not applied");

   a_sync_deferred: assert property (
      pend_q && sync_q && !slow_rise |=> $stable(state_q) && pend_q)
      else $error("deferred start or stop applied early");

   a_sync_slow_edge: assert property (
      pend_q && sync_q && slow_rise |=> running == $past(run_q))
      else $error("start or stop missed the slow clock edge");

   a_latch_high: assert property (
      s_lo_read |=> cnt_hi_q == $past(count_value_i[15:8]))
      else $error("high count byte not captured");

   a_latch_all: assert property (
      s_lo_read ##0 latch_q |=> wrap_lat_q == $past(wrap_count_i))
      else $error("wrap count not captured with low count read");

   a_latch_upper: assert property (
      rd_acc && hit_w0 && wrap_live && !latch_q
      |=> wrap_lat_q[23:8] == $past(wrap_count_i[23:8]))
      else $error("upper wrap bytes not captured");

   a_pulse_route: assert property (
      1'b1 |=> pulse_a_out_o == $past(src[code_a]) && pulse_b_out_o == $past(src[code_b]))
      else $error("event pulse does not follow selected source");

   a_none_quiet: assert property (
      code_a[2:0] == 3'h7 |=> !pulse_a_out_o)
      else $error("pulse seen with no-event code");

   a_joint_match: assert property (
      JOINT_EN && code_a == 4'(SRC_JOINT_A) && wrap_at_match_a_i && count_match_a_evt_i
      |=> pulse_a_out_o)
      else $error("joint match event not routed");

   // set wins over a clear in the same cycle
   a_irq_level: assert property (
      sts_set[IRQ_PULSE_A] |=> sts_q[IRQ_PULSE_A] && (irq_o || !en_q[IRQ_PULSE_A]))
      else $error("interrupt status or level wrong");

   a_start_status: assert property (
      start_evt |=> sts_q[IRQ_START] && running)
      else $error("start not flagged or not running");

   a_state_bit: assert property (
      s_ctrl_write ##1 !sync_q[*2] |-> running == $past(run_q))
      else $error("state bit does not follow running state");
endmodule : mte_timer_ctrl

// ### rtl/mte_pkg.sv
// Purpose: shared constants for the timer control and event select block
// Assumes: 8-bit registers, one per aligned 32-bit word
// Notes: offsets are byte addresses on the register bus
package mte_pkg;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h80;
   localparam logic [7:0] OFS_VIEW_SEL = 8'h88;
   localparam logic [7:0] OFS_CNT_LO = 8'h8c;
   localparam logic [7:0] OFS_CNT_HI = 8'h90;
   localparam logic [7:0] OFS_WRAP0 = 8'h94;
   localparam logic [7:0] OFS_WRAP1 = 8'h98;
   localparam logic [7:0] OFS_EVT_SEL = 8'h9c;
   localparam logic [7:0] OFS_WRAP2 = 8'ha0;
   localparam logic [7:0] OFS_IRQ_STS = 8'ha4;
   localparam logic [7:0] OFS_IRQ_CLR = 8'ha8;
   localparam logic [7:0] OFS_IRQ_EN = 8'hac;
   // timer_control fields
   localparam int CTRL_RUN = 0;
   localparam int CTRL_SYNC = 1;
   localparam int CTRL_STATE = 2;
   localparam int CTRL_LATCH = 3;
   localparam logic CTRL_SYNC_RST = 1'b1;
   localparam logic CTRL_RUN_RST = 1'b0;
   localparam logic CTRL_LATCH_RST = 1'b0;
   // view selector fields
   localparam int VSEL_CNT_LSB = 0;
   localparam int VSEL_WRAP_LSB = 4;
   localparam logic [2:0] VSEL_LIVE = 3'h0;
   localparam logic [7:0] VSEL_MASK = 8'h77;
   // event select layout
   localparam int EVT_A_LSB = 0;
   localparam int EVT_B_LSB = 4;
   localparam logic [7:0] EVT_MASK_NARROW = 8'h77;
   localparam logic [7:0] EVT_MASK_WIDE = 8'hff;
   localparam logic [7:0] EVT_RST = 8'h00;
   // event source codes, index into the source vector
   localparam int SRC_CNT_WRAP = 0;
   localparam int SRC_CNT_MA = 1;
   localparam int SRC_CNT_MB = 2;
   localparam int SRC_WRAP_WRAP = 3;
   localparam int SRC_WRAP_MA = 4;
   localparam int SRC_WRAP_MB = 5;
   localparam int SRC_JOINT_A = 8;
   localparam int SRC_JOINT_B = 9;
   localparam int SRC_N = 16;
   // interrupt status bits
   localparam int IRQ_PULSE_A = 0;
   localparam int IRQ_PULSE_B = 1;
   localparam int IRQ_START = 2;
   localparam int IRQ_STOP = 3;
   localparam int IRQ_N = 4;
   typedef enum logic {MTE_IDLE, MTE_RUNNING} mte_state_t;
endpackage : mte_pkg

// ### verification/mte_far_model.sv
// Purpose: far side model, timer datapath events, counter values and slow clock
// Assumes: bench drives event pulses and values right after clk_i edges
// Notes: slow clock runs free near 32 kHz, unrelated in phase to clk_i
`timescale 1ns/10ps
module mte_far_model (
   // stimulus from bench
   input wire logic [7:0] fire_i,
   input wire logic [15:0] cnt_i,
   input wire logic [23:0] wrap_i,
   // towards the design
   output logic slow_clk_o,
   output logic [7:0] evt_o,
   output logic [15:0] cnt_o,
   output logic [23:0] wrap_o
);
   // events: [5:0] pulses, [6] wrap at match a, [7] wrap at match b
   assign evt_o = fire_i;
   assign cnt_o = cnt_i;
   assign wrap_o = wrap_i;
   initial begin
      slow_clk_o = 1'b0;
      forever #15625 slow_clk_o = ~slow_clk_o;
   end
endmodule : mte_far_model

// ### verification/tb_mte_timer_ctrl.sv
// Purpose: self-checking bench for mte_timer_ctrl
// Assumes: wide and narrow event fields side by side, lane 0 off in one case only
// Notes: reset reads first, then event rows, run, latch and interrupt cases
`timescale 1ns/10ps
module tb_mte_timer_ctrl;
   import mte_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, slow, ack, pa, pb, run, irq, pa_n, pb_n;
   logic [3:0] sel;
   logic [7:0] adr, fire, evt;
   logic [31:0] wdat, rdat, dat_o, rdat_n, dat_n;
   logic [15:0] cnt, cnt_v;
   logic [23:0] wrap, wrap_v;
   int n_fail = 0;
   int checks_done = 0;
   int cyc_n = 0;
   // select byte, fired sources, expected pulse a and b
   logic [17:0] rows [15] = '{{8'h00, 8'h01, 2'b11}, {8'h11, 8'h02, 2'b11},
      {8'h22, 8'h04, 2'b11}, {8'h33, 8'h08, 2'b11}, {8'h44, 8'h10, 2'b11},
      {8'h55, 8'h20, 2'b11}, {8'h66, 8'hff, 2'b00}, {8'h77, 8'hff, 2'b00},
      {8'h88, 8'h42, 2'b11}, {8'h99, 8'h84, 2'b11}, {8'hff, 8'hff, 2'b00},
      {8'haf, 8'hff, 2'b00}, {8'h80, 8'h02, 2'b00}, {8'h08, 8'h40, 2'b00},
      {8'h10, 8'h01, 2'b10}};
   mte_far_model u_far (.fire_i(fire), .cnt_i(cnt), .wrap_i(wrap),
      .slow_clk_o(slow), .evt_o(evt), .cnt_o(cnt_v), .wrap_o(wrap_v));
   mte_timer_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .slow_clk_i(slow), .count_wrap_evt_i(evt[0]),
      .count_match_a_evt_i(evt[1]), .count_match_b_evt_i(evt[2]),
      .wrap_count_wrap_evt_i(evt[3]), .wrap_count_match_a_evt_i(evt[4]),
      .wrap_count_match_b_evt_i(evt[5]), .wrap_at_match_a_i(evt[6]),
      .wrap_at_match_b_i(evt[7]), .count_value_i(cnt_v), .wrap_count_i(wrap_v),
      .pulse_a_out_o(pa), .pulse_b_out_o(pb), .timer_running_o(run), .irq_o(irq));
   // narrow variant on the same bus and events
   mte_timer_ctrl #(.EVT_W(3)) u_dut_narrow (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_n), .wb_ack_o(), .slow_clk_i(slow), .count_wrap_evt_i(evt[0]),
      .count_match_a_evt_i(evt[1]), .count_match_b_evt_i(evt[2]),
      .wrap_count_wrap_evt_i(evt[3]), .wrap_count_match_a_evt_i(evt[4]),
      .wrap_count_match_b_evt_i(evt[5]), .wrap_at_match_a_i(evt[6]),
      .wrap_at_match_b_i(evt[7]), .count_value_i(cnt_v), .wrap_count_i(wrap_v),
      .pulse_a_out_o(pa_n), .pulse_b_out_o(pb_n), .timer_running_o(), .irq_o());
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // classic cycle, entered and left right after a clk_i edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      rdat_n = dat_n;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rc
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      {rst_i, cyc, stb, we, adr, wdat, fire, cnt, wrap} = {1'b1, 91'h0};
      sel = 4'hf;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rc(OFS_CTRL, 32'h02);
      rc(OFS_EVT_SEL, 32'h00);
      rc(8'h84, 32'h00);
      $display("reset test done");
      foreach (rows[i]) begin
         wb(1'b1, OFS_EVT_SEL, {24'h0, rows[i][17:10]});
         rc(OFS_EVT_SEL, {24'h0, rows[i][17:10]});
         fire <= rows[i][9:2];
         @(posedge clk_i);
         fire <= 8'h00;
         #1 chk({pa, pb}, rows[i][1:0]);
         @(posedge clk_i);
         #1 chk({pa, pb}, 2'b00);
         @(posedge clk_i);
      end
      $display("event rows done");
      wb(1'b1, OFS_CTRL, 32'h01);
      chk(run, 1'b1);
      rc(OFS_CTRL, 32'h05);
      wb(1'b1, OFS_CTRL, 32'h00);
      chk(run, 1'b0);
      $display("immediate run test done");
      @(posedge slow);
      repeat (10) @(posedge clk_i);
      wb(1'b1, OFS_CTRL, 32'h03);
      rc(OFS_CTRL, 32'h03);
      @(posedge slow);
      chk(run, 1'b0);
      repeat (6) @(posedge clk_i);
      chk(run, 1'b1);
      wb(1'b1, OFS_CTRL, 32'h02);
      rc(OFS_CTRL, 32'h06);
      @(posedge slow);
      repeat (6) @(posedge clk_i);
      chk(run, 1'b0);
      $display("synced run test done");
      wb(1'b1, OFS_CTRL, 32'h00);
      cnt <= 16'h1234;
      wrap <= 24'habcdef;
      rc(OFS_CNT_LO, 32'h34);
      cnt <= 16'h0000;
      rc(OFS_CNT_HI, 32'h12);
      rc(OFS_WRAP0, 32'hef);
      wrap <= 24'h000000;
      rc(OFS_WRAP1, 32'hcd);
      rc(OFS_WRAP2, 32'hab);
      wb(1'b1, OFS_CTRL, 32'h08);
      cnt <= 16'h5678;
      wrap <= 24'h112233;
      rc(OFS_CNT_LO, 32'h78);
      cnt <= 16'h0000;
      wrap <= 24'h000000;
      rc(OFS_CNT_HI, 32'h56);
      rc(OFS_WRAP0, 32'h33);
      rc(OFS_WRAP1, 32'h22);
      rc(OFS_WRAP2, 32'h11);
      wb(1'b1, OFS_VIEW_SEL, 32'h11);
      rc(OFS_CNT_LO, 32'h00);
      $display("latch test done");
      wb(1'b1, OFS_IRQ_CLR, 32'h0f);
      rc(OFS_IRQ_STS, 32'h00);
      wb(1'b1, OFS_EVT_SEL, 32'h00);
      wb(1'b1, OFS_IRQ_EN, 32'h01);
      fire <= 8'h01;
      @(posedge clk_i);
      fire <= 8'h00;
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b1);
      rc(OFS_IRQ_STS, 32'h03);
      wb(1'b1, OFS_IRQ_EN, 32'h0c);
      chk(irq, 1'b0);
      rc(OFS_IRQ_CLR, 32'h00);
      wb(1'b1, OFS_IRQ_CLR, 32'h03);
      rc(OFS_IRQ_STS, 32'h00);
      wb(1'b1, OFS_IRQ_EN, 32'h0f);
      chk(irq, 1'b0);
      $display("irq test done");
      // write with byte lane 0 off is ignored
      sel <= 4'he;
      wb(1'b1, OFS_EVT_SEL, 32'h55);
      sel <= 4'hf;
      rc(OFS_EVT_SEL, 32'h00);
      // narrow variant masks bits 7 and 3, wide keeps joint codes
      wb(1'b1, OFS_EVT_SEL, 32'h98);
      rc(OFS_EVT_SEL, 32'h98);
      chk(rdat_n, 32'h10);
      fire <= 8'h42;
      @(posedge clk_i);
      fire <= 8'h00;
      #1 chk({pa, pb, pa_n, pb_n}, 4'b1001);
      @(posedge clk_i);
      // reset in mid-run while running in latch mode 1
      wb(1'b1, OFS_CTRL, 32'h09);
      chk(run, 1'b1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(run, 1'b0);
      rc(OFS_CTRL, 32'h02);
      rc(OFS_EVT_SEL, 32'h00);
      $display("awkward cases done");
      test_done();
   end
endmodule : tb_mte_timer_ctrl
